// >>> rtcrb_regs.sv
`default_nettype none
// Contract
// - Day/date register bit 7 is the second alarm day/date mask, read/write.
// - Bit 6 selects date match when 0, weekday match when 1.
// - Day/date held as BCD: tens in bits 5:4, units in bits 3:0.
// - Countdown present value is an 8-bit read-only register resetting to zero.
// - In repeat mode at zero the countdown reloads from the reload register.
// - User storage bytes 0x16 to 0x55 are read/write, undefined after power-on.
// - Power bit 2 clear gives automatic supply choice; set gives manual choice.
// - In manual mode bit 3 selects main supply at 0, backup at 1.
// - Power bits 1:0 pick comparator mode, power-management mode, or reserved codes.
// - With masks clear, the alarm fires only when all fields match.
module rtcrb_regs
   import rtcrb_pkg::*;
(
   input wire logic clk_sys, // 40 MHz system clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic clk_en, // Freezes all state while low.
   input wire logic host_wr, // Host write strobe, one cycle.
   input wire logic host_rd, // Host read strobe, one cycle.
   input wire logic [7:0] host_addr, // Register address.
   input wire logic [7:0] host_wdata, // Write data.
   input wire logic timer_tick, // Countdown decrement request.
   input wire logic timer_run, // Countdown running.
   input wire logic timer_repeat, // Repeat mode enable.
   input wire logic time_sel_match, // Minute/hour matched (or masked) upstream.
   input wire logic [7:0] cur_date_bcd, // Present date of month, BCD.
   input wire logic [7:0] cur_day_bcd, // Present weekday, BCD.
   input wire logic supply_auto_backup, // Automatic supply decision.
   output logic [7:0] host_rdata, // Read data, valid one cycle after strobe.
   output logic host_rvalid, // Read data valid pulse.
   output logic alarm2_match, // Second alarm match, high every cycle the match holds.
   output logic countdown_zero, // Countdown reached zero pulse.
   output logic use_backup_supply, // Supply in use: 1 backup, 0 main.
   output logic [1:0] comparator_mode, // Comparator function code.
   output logic manual_supply_override, // Manual supply choice active.
   output logic backup_supply_choice // Manual backup selection bit.
);
   // ==========================================================
   // Address decode.
   logic [7:0] alarm2_day_date_match_reg;
   logic [7:0] countdown_present_value_reg;
   logic [7:0] countdown_reload_value_reg;
   logic [3:0] power_management_config_reg;
   logic [7:0] ram_rdata;
   logic [5:0] ram_offset;
   logic in_ram;
   logic [7:0] host_rdata_next;
   logic [7:0] day_date_target;
   logic fields_match;
   logic second_alarm_daydate_mask;
   logic weekday_or_monthday_select;

   // The storage window is checked by range; the offset below wraps for addresses
   // under the window, but in_ram then blocks the access.
   assign in_ram = (host_addr >= USER_STORAGE_FIRST_OFS) && (host_addr <= USER_STORAGE_LAST_OFS);
   assign ram_offset = 6'(host_addr - USER_STORAGE_FIRST_OFS);

   // User storage bank.
   // Storage has no reset; reads of unwritten bytes return whatever powered up.
   // user storage bytes
   rtcrb_user_ram #(
      .DEPTH(USER_STORAGE_DEPTH),
      .AW(6)
   ) u_ram (
      .clk_sys(clk_sys),
      .clk_en(clk_en),
      .wr_en(host_wr && in_ram),
      .addr(ram_offset),
      .wr_data(host_wdata),
      .rd_data(ram_rdata)
   );

   // ==========================================================
   // Second alarm day/date register; whole byte is read/write.
   // Illegal digit values are kept as written; the compare treats them literally.
   // mask bit stored
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         alarm2_day_date_match_reg <= ALARM2_DAY_DATE_RESET;
      end else if (clk_en && host_wr && host_addr == ALARM2_DAY_DATE_MATCH_OFS) begin
         alarm2_day_date_match_reg <= host_wdata;
      end
   end

   // Reload value register.
   // A new reload value is used at the next reload, never by a count in progress.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         countdown_reload_value_reg <= COUNTDOWN_RELOAD_RESET;
      end else if (clk_en && host_wr && host_addr == COUNTDOWN_RELOAD_VALUE_OFS) begin
         countdown_reload_value_reg <= host_wdata;
      end
   end

   // Power management: only the low nibble is kept.
   // upper bits dropped
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         power_management_config_reg <= POWER_MANAGEMENT_RESET[3:0];
      end else if (clk_en && host_wr && host_addr == POWER_MANAGEMENT_CONFIG_OFS) begin
         power_management_config_reg <= host_wdata[3:0] & PWR_WRITABLE_MASK[3:0];
      end
   end

   // ==========================================================
   // Countdown. Host writes never reach it; it is steered only by the timer controls.
   // A count at zero stays there until a tick in repeat mode reloads it, so
   // one-shot use leaves the zero visible to the host until the next load.
   // The zero pulse marks only the step from one to zero, never the reload.
   // read-only count
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         countdown_present_value_reg <= COUNTDOWN_PRESENT_RESET;
         countdown_zero <= 1'b0;
      end else if (clk_en) begin
         countdown_zero <= 1'b0;
         if (timer_run && timer_tick) begin
            if (countdown_present_value_reg == 8'h01) begin
               countdown_present_value_reg <= 8'h00;
               countdown_zero <= 1'b1;
            end else if (countdown_present_value_reg == 8'h00) begin
               if (timer_repeat) begin
                  countdown_present_value_reg <= countdown_reload_value_reg;
               end
            end else begin
               countdown_present_value_reg <= countdown_present_value_reg - 8'h01;
            end
         end
      end
   end

   // ==========================================================
   // Alarm day/date compare; the field is BCD in bits 5:0.
   // Minute and hour arrive already combined in time_sel_match, so a late
   // upstream match delays this alarm as well.
   assign second_alarm_daydate_mask = alarm2_day_date_match_reg[DAYDATE_MASK_BIT];
   assign weekday_or_monthday_select = alarm2_day_date_match_reg[DAYDATE_SEL_BIT];
   // Bits 7:6 of the present date and weekday never take part in the compare.
   // date or weekday
   assign day_date_target = weekday_or_monthday_select ? cur_day_bcd : cur_date_bcd;
   assign fields_match =
      (day_date_target[DAYDATE_TENS_HI:DAYDATE_TENS_LO] ==
       alarm2_day_date_match_reg[DAYDATE_TENS_HI:DAYDATE_TENS_LO]) &&
      (day_date_target[DAYDATE_UNITS_HI:DAYDATE_UNITS_LO] ==
       alarm2_day_date_match_reg[DAYDATE_UNITS_HI:DAYDATE_UNITS_LO]);

   // Mask bit set lets the day/date field pass unconditionally.
   // all fields match
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         alarm2_match <= 1'b0;
      end else if (clk_en) begin
         alarm2_match <= time_sel_match && (second_alarm_daydate_mask || fields_match);
      end
   end

   // ==========================================================
   // Supply selection and mode outputs, registered.
   // Registering the choice costs one cycle of latency but keeps a glitch on
   // the automatic decision from reaching the supply switch combinationally.
   // Reserved comparator codes are stored and passed on as written.
   // auto or manual
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         use_backup_supply <= 1'b0;
         comparator_mode <= RTCRB_MODE_COMPARATOR;
         manual_supply_override <= 1'b0;
         backup_supply_choice <= 1'b0;
      end else if (clk_en) begin
         manual_supply_override <= power_management_config_reg[PWR_MANUAL_BIT];
         backup_supply_choice <= power_management_config_reg[PWR_BACKUP_BIT];
         comparator_mode <= power_management_config_reg[PWR_MODE_HI:PWR_MODE_LO];
         if (power_management_config_reg[PWR_MANUAL_BIT]) begin
            use_backup_supply <= power_management_config_reg[PWR_BACKUP_BIT];
         end else begin
            use_backup_supply <= supply_auto_backup;
         end
      end
   end

   // ==========================================================
   // Read data selection. The storage answers without a clock, so every address
   // shares one cycle of latency. A read in the same cycle as a write to the
   // same register returns the old value.
   always_comb begin
      host_rdata_next = UNMAPPED_READ_VALUE;
      if (in_ram) begin
         host_rdata_next = ram_rdata;
      end else begin
         case (host_addr)
            ALARM2_DAY_DATE_MATCH_OFS: host_rdata_next = alarm2_day_date_match_reg;
            COUNTDOWN_PRESENT_VALUE_OFS: host_rdata_next = countdown_present_value_reg;
            COUNTDOWN_RELOAD_VALUE_OFS: host_rdata_next = countdown_reload_value_reg;
            POWER_MANAGEMENT_CONFIG_OFS: host_rdata_next = {4'h0, power_management_config_reg};
            default: host_rdata_next = UNMAPPED_READ_VALUE;
         endcase
      end
   end

   // Read answer register; the data holds until the next read strobe.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         host_rvalid <= 1'b0;
         host_rdata <= UNMAPPED_READ_VALUE;
      end else if (clk_en) begin
         host_rvalid <= host_rd;
         if (host_rd) begin
            host_rdata <= host_rdata_next;
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtcrb_pkg.sv
`default_nettype none
package rtcrb_pkg;
   // ==========================================================
   // Register offsets.
   localparam logic [7:0] ALARM2_DAY_DATE_MATCH_OFS = 8'h13;
   localparam logic [7:0] COUNTDOWN_PRESENT_VALUE_OFS = 8'h14;
   localparam logic [7:0] COUNTDOWN_RELOAD_VALUE_OFS = 8'h15;
   localparam logic [7:0] USER_STORAGE_FIRST_OFS = 8'h16;
   localparam logic [7:0] USER_STORAGE_LAST_OFS = 8'h55;
   localparam logic [7:0] POWER_MANAGEMENT_CONFIG_OFS = 8'h56;
   localparam int USER_STORAGE_DEPTH = 64;
   // ==========================================================
   // Field positions.
   localparam int DAYDATE_MASK_BIT = 7;
   localparam int DAYDATE_SEL_BIT = 6;
   localparam int DAYDATE_TENS_HI = 5;
   localparam int DAYDATE_TENS_LO = 4;
   localparam int DAYDATE_UNITS_HI = 3;
   localparam int DAYDATE_UNITS_LO = 0;
   localparam int PWR_BACKUP_BIT = 3;
   localparam int PWR_MANUAL_BIT = 2;
   localparam int PWR_MODE_HI = 1;
   localparam int PWR_MODE_LO = 0;
   localparam logic [7:0] PWR_WRITABLE_MASK = 8'h0f;
   // ==========================================================
   // Reset values.
   localparam logic [7:0] ALARM2_DAY_DATE_RESET = 8'h00;
   localparam logic [7:0] COUNTDOWN_PRESENT_RESET = 8'h00;
   localparam logic [7:0] COUNTDOWN_RELOAD_RESET = 8'h00;
   localparam logic [7:0] POWER_MANAGEMENT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
   // Comparator function codes.
   typedef enum logic [1:0] {
      RTCRB_MODE_COMPARATOR = 2'b00,
      RTCRB_MODE_POWER_MGMT = 2'b01,
      RTCRB_MODE_RSVD2 = 2'b10,
      RTCRB_MODE_RSVD3 = 2'b11
   } rtcrb_mode_t;
endpackage
`default_nettype wire

// >>> rtcrb_user_ram.sv
`default_nettype none
module rtcrb_user_ram
   import rtcrb_pkg::*;
#(
   parameter int DEPTH = USER_STORAGE_DEPTH,
   parameter int AW = 6
) (
   input wire logic clk_sys, // System clock.
   input wire logic clk_en, // Clock enable.
   input wire logic wr_en, // Write strobe.
   input wire logic [AW-1:0] addr, // Byte index.
   input wire logic [7:0] wr_data, // Write byte.
   output logic [7:0] rd_data // Read byte, follows addr without a clock.
);
   // ==========================================================
   // Storage has no reset, so its power-up contents are undefined.
   logic [7:0] mem [DEPTH];

   // Write port.
   always_ff @(posedge clk_sys) begin
      if (clk_en && wr_en) begin
         mem[addr] <= wr_data;
      end
   end

   // Asynchronous read port. The caller registers the byte, so every register
   // of the bank answers with the same latency and no extra stage is needed.
   assign rd_data = mem[addr];
endmodule
`default_nettype wire

// >>> rtcrb_regs_properties.sv
`default_nettype none
module rtcrb_regs_chk (
   input wire logic clk_sys, // Clock.
   input wire logic rst, // Reset.
   input wire logic clk_en, // Run enable.
   input wire logic host_wr, // Write strobe.
   input wire logic host_rd, // Read strobe.
   input wire logic [7:0] host_addr, // Address.
   input wire logic [7:0] host_wdata, // Write data.
   input wire logic timer_tick, // Tick.
   input wire logic timer_run, // Run.
   input wire logic time_sel_match, // Upstream match.
   input wire logic supply_auto_backup, // Auto decision.
   input wire logic host_rvalid, // Read valid.
   input wire logic alarm2_match, // Alarm.
   input wire logic countdown_zero, // Zero pulse.
   input wire logic use_backup_supply, // Supply.
   input wire logic [1:0] comparator_mode, // Mode.
   input wire logic manual_supply_override, // Manual.
   input wire logic backup_supply_choice // Backup bit.
);
   // ==========================================================
   // All checks share one domain, so reset masks them all.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_read_answer: assert property (host_rd && clk_en |=> host_rvalid)
      else $error("read strobe without valid");
   a_valid_cause: assert property (host_rvalid |-> $past(host_rd && clk_en))
      else $error("valid without read strobe");
   a_mode_follows: assert property ((clk_en && host_wr && host_addr == 8'h56) ##1 clk_en
      |=> comparator_mode == $past(host_wdata[1:0], 2)) else $error("mode not loaded");
   a_manual_follows: assert property ((clk_en && host_wr && host_addr == 8'h56) ##1 clk_en
      |=> manual_supply_override == $past(host_wdata[2], 2)) else $error("manual not loaded");
   a_backup_follows: assert property ((clk_en && host_wr && host_addr == 8'h56) ##1 clk_en
      |=> backup_supply_choice == $past(host_wdata[3], 2)) else $error("backup not loaded");
   // Both supply checks wait for a settled cycle, since the path may be registered.
   a_supply_manual: assert property (manual_supply_override && $past(manual_supply_override)
      && $stable(backup_supply_choice) |-> use_backup_supply == backup_supply_choice)
      else $error("manual supply not honoured");
   a_supply_auto: assert property (!manual_supply_override && !$past(manual_supply_override)
      && $stable(supply_auto_backup) |-> use_backup_supply == supply_auto_backup)
      else $error("automatic supply not honoured");
   a_zero_cause: assert property (countdown_zero |-> $past(timer_tick && timer_run))
      else $error("zero pulse without tick");
   a_alarm_cause: assert property (alarm2_match |-> $past(time_sel_match))
      else $error("alarm without time match");
endmodule
bind rtcrb_regs rtcrb_regs_chk chk (.*);
`default_nettype wire

// >>> rtcrb_regs_bench.sv
`default_nettype none
module rtcrb_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst = 1, clk_en = 1, host_wr = 0, host_rd = 0, timer_tick = 0;
   logic timer_run = 0, timer_repeat = 0, time_sel_match = 0, supply_auto_backup = 0;
   logic [7:0] host_addr = 0, host_wdata = 0, cur_date_bcd = 0, cur_day_bcd = 0, host_rdata;
   logic host_rvalid, alarm2_match, countdown_zero, use_backup_supply, mso, bsc;
   logic [1:0] comparator_mode;
   int n_errors = 0, n_checks = 0;
   rtcrb_regs uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .host_wr(host_wr),
      .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
      .timer_tick(timer_tick), .timer_run(timer_run), .timer_repeat(timer_repeat),
      .time_sel_match(time_sel_match), .cur_date_bcd(cur_date_bcd), .cur_day_bcd(cur_day_bcd),
      .supply_auto_backup(supply_auto_backup), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .alarm2_match(alarm2_match), .countdown_zero(countdown_zero),
      .use_backup_supply(use_backup_supply), .comparator_mode(comparator_mode),
      .manual_supply_override(mso), .backup_supply_choice(bsc));
   // ==========================================================
   // Clock, and a watchdog far beyond the roughly 130 cycles needed.
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Every driver starts 1 ns after an edge, so the edge never races the drive.
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // An idle edge ends each transfer, so no strobe falls and rises in one step.
   task automatic wr(logic [7:0] a, logic [7:0] d);
      host_wr = 1;
      host_addr = a;
      host_wdata = d;
      cyc(1);
      host_wr = 0;
      cyc(1);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      host_rd = 1;
      host_addr = a;
      cyc(1);
      host_rd = 0;
      chk("host_rvalid", 1, host_rvalid);
      chk($sformatf("rdata %h", a), e, host_rdata);
      cyc(1);
   endtask
   task automatic tk;
      timer_tick = 1;
      cyc(1);
      timer_tick = 0;
   endtask
   task automatic t_reset;
      rd(8'h13, 8'h00);
      rd(8'h14, 8'h00);
      rd(8'h15, 8'h00);
      rd(8'h56, 8'h00);
      chk("mode", 8'h00, comparator_mode);
   endtask
   // Alarm select, mask and BCD compare, with write-then-read checks.
   task automatic t_daydate;
      wr(8'h13, 8'hc5);
      rd(8'h13, 8'hc5);
      wr(8'h13, 8'h31);
      rd(8'h13, 8'h31);
      time_sel_match = 1;
      cur_date_bcd = 8'h25;
      cur_day_bcd = 8'h03;
      wr(8'h13, 8'h25);
      cyc(2);
      chk("alarm date", 1, alarm2_match);
      cur_date_bcd = 8'h24;
      cyc(2);
      chk("alarm units", 0, alarm2_match);
      wr(8'h13, 8'h43);
      cyc(2);
      chk("alarm day", 1, alarm2_match);
      wr(8'h13, 8'h03);
      cyc(2);
      chk("alarm date sel", 0, alarm2_match);
      wr(8'h13, 8'h80);
      cyc(2);
      chk("alarm masked", 1, alarm2_match);
      time_sel_match = 0;
      cyc(2);
      chk("alarm no time", 0, alarm2_match);
   endtask
   task automatic t_count;
      wr(8'h14, 8'h55);
      rd(8'h14, 8'h00);
      wr(8'h15, 8'h02);
      rd(8'h15, 8'h02);
      timer_run = 1;
      timer_repeat = 1;
      tk();
      rd(8'h14, 8'h02);
      tk();
      rd(8'h14, 8'h01);
      tk();
      chk("zero pulse", 1, countdown_zero);
      rd(8'h14, 8'h00);
      chk("zero ends", 0, countdown_zero);
      tk();
      rd(8'h14, 8'h02);
   endtask
   // Clock enable low freezes every register, ticks and writes included.
   task automatic t_freeze;
      clk_en = 0;
      tk();
      wr(8'h15, 8'h99);
      clk_en = 1;
      rd(8'h14, 8'h02);
      rd(8'h15, 8'h02);
   endtask
   task automatic t_power;
      wr(8'h56, 8'hff);
      rd(8'h56, 8'h0f);
      for (int i = 0; i < 4; i++) begin
         wr(8'h56, 8'(i));
         cyc(2);
         chk("mode", 8'(i), comparator_mode);
      end
      supply_auto_backup = 1;
      wr(8'h56, 8'h04);
      cyc(2);
      chk("manual main", 0, use_backup_supply);
      chk("manual flag", 1, mso);
      wr(8'h56, 8'h0c);
      cyc(2);
      chk("manual backup", 1, use_backup_supply);
      chk("backup flag", 1, bsc);
      wr(8'h56, 8'h08);
      cyc(2);
      chk("auto backup", 1, use_backup_supply);
      supply_auto_backup = 0;
      cyc(2);
      chk("auto main", 0, use_backup_supply);
   endtask
   task automatic t_ram;
      wr(8'h16, 8'ha5);
      wr(8'h55, 8'h3c);
      wr(8'h57, 8'h77);
      rd(8'h16, 8'ha5);
      rd(8'h55, 8'h3c);
      rd(8'h57, 8'h00);
   endtask
   initial begin
      cyc(20);
      rst = 0;
      t_reset();
      t_daydate();
      t_count();
      t_freeze();
      t_power();
      t_ram();
      summarize();
   end
endmodule
`default_nettype wire
